// ===== include/lcdsw_regs.svh
// Purpose: register offsets, fields, reset values and timing counts of the segment lcd driver
// Assumes: 32-bit apb, one register per aligned word
// Notes: included by the design modules, the property module and the bench
`ifndef LCDSW_REGS_SVH
`define LCDSW_REGS_SVH

`define LCDSW_OFS_CTRL 12'h000
`define LCDSW_OFS_FLASH 12'h004
`define LCDSW_OFS_SUPPLY 12'h008
`define LCDSW_OFS_STATUS 12'h00C
`define LCDSW_OFS_SEGMEM 12'h040

// control register fields
`define LCDSW_CTRL_DUTY_LSB 0
`define LCDSW_CTRL_BASE_LSB 2
`define LCDSW_CTRL_ENABLE_BIT 5
`define LCDSW_CTRL_BANK_BIT 6
`define LCDSW_CTRL_RESET 32'h0000_0000

// flash control register fields
`define LCDSW_FLASH_RATE_LSB 0
`define LCDSW_FLASH_ALL_BIT 3
`define LCDSW_FLASH_EN_BIT 7
`define LCDSW_FLASH_RESET 32'h0000_0000

// supply config register fields
`define LCDSW_SUPPLY_SRC_LSB 0
`define LCDSW_SUPPLY_RESET 32'h0000_0000

// timing: base frequency at code zero in tenths of a hertz
`define LCDSW_SYS_CLK_HZ 100000000
`define LCDSW_BASE_FREQ_DHZ 20493
`define LCDSW_BASE_DIV ((`LCDSW_SYS_CLK_HZ * 10) / `LCDSW_BASE_FREQ_DHZ)
`define LCDSW_BLINK_EXP_MIN 5

`endif

// ===== include/lcdsw_pkg.sv
// Purpose: shared types of the segment lcd driver
// Assumes: offsets and fields live in lcdsw_regs.svh
// Notes: none
package lcdsw_pkg;
    typedef enum logic [1:0] {
        LCDSW_DUTY_1 = 2'h0,
        LCDSW_DUTY_2 = 2'h1,
        LCDSW_DUTY_3 = 2'h2,
        LCDSW_DUTY_4 = 2'h3
    } lcdsw_duty_t;

    typedef enum logic [1:0] {
        LCDSW_SUP_VDD = 2'h0,
        LCDSW_SUP_INTREF = 2'h1,
        LCDSW_SUP_EXTPIN = 2'h2,
        LCDSW_SUP_NONE = 2'h3
    } lcdsw_supply_t;
endpackage : lcdsw_pkg

// ===== src/lcdsw_rate_gen.sv
// Purpose: waveform base tick and blink phase generator
// Assumes: sys_clk at 100 MHz
// Notes: base tick is one cycle wide
`timescale 1ns/100ps
`include "lcdsw_regs.svh"
module lcdsw_rate_gen #(
    parameter int BASE_DIV = `LCDSW_BASE_DIV
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [2:0] baseFrequencySelect,
    input wire logic [2:0] flashRateExponent,
    input wire logic blinkRun,
    output logic baseTick,
    output logic blinkOff
);
    initial begin
        if (BASE_DIV < 2 || BASE_DIV > 65536) begin
            $error("lcdsw_rate_gen: BASE_DIV out of range");
        end
    end

    logic [15:0] preCount;
    logic [6:0] octCount;
    logic [11:0] blinkCount;

    wire preWrap = (preCount == 16'(BASE_DIV - 1));
    // each select step halves the base frequency
    wire [6:0] octLimit = 7'((8'h01 << baseFrequencySelect) - 8'h01);
    wire octWrap = preWrap && (octCount >= octLimit);
    // half of the 2^(5+n) divider so on and off phases are equal
    wire [11:0] halfLimit = 12'((13'h0010 << flashRateExponent) - 13'h0001);
    wire blinkWrap = baseTick && (blinkCount >= halfLimit);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            preCount <= 16'h0000;
            octCount <= 7'h00;
            baseTick <= 1'b0;
        end else begin
            preCount <= preWrap ? 16'h0000 : preCount + 16'h0001;
            octCount <= octWrap ? 7'h00 : (preWrap ? octCount + 7'h01 : octCount);
            baseTick <= octWrap;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            blinkCount <= 12'h000;
            blinkOff <= 1'b0;
        end else if (!blinkRun) begin
            blinkCount <= 12'h000;
            blinkOff <= 1'b0;
        end else if (blinkWrap) begin
            blinkCount <= 12'h000;
            blinkOff <= ~blinkOff;
        end else if (baseTick) begin
            blinkCount <= blinkCount + 12'h001;
        end
    end
endmodule : lcdsw_rate_gen

// ===== src/lcdsw_top.sv
// Purpose: segment lcd waveform, segment memory, blink and supply control behind apb
// Assumes: pins driven digitally; analog bias and shaping happen in the pad ring
// Notes: output enables are active low, high (released) from reset
`timescale 1ns/100ps
`include "lcdsw_regs.svh"
module lcdsw_top #(
    parameter int BASE_DIV = `LCDSW_BASE_DIV,
    parameter int FP_COUNT = 40
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] backplaneOutput,
    output logic [2:0] backplaneOutputOe_b,
    output logic [FP_COUNT-1:0] frontplaneOutput,
    output logic [FP_COUNT-1:0] frontplaneOutputOe_b,
    output logic sharedPlaneOutput,
    output logic sharedPlaneOutputOe_b,
    output logic [2:0] supplySwitch
);
    localparam int BYTES = (FP_COUNT + 2) / 2;
    localparam int IDXW = $clog2(BYTES);

    initial begin
        if (FP_COUNT != 40) begin
            $error("lcdsw_top: only forty dedicated frontplanes are supported");
        end
    end

    // software registers
    logic [1:0] dutySelect;
    logic [2:0] baseFrequencySelect;
    logic displayEnable;
    logic memoryBankSelect;
    logic [2:0] flashRateExponent;
    logic blinkAllSelect;
    logic blinkEnable;
    logic [1:0] powerSourceSelect;
    logic [7:0] segmentMemory [2][BYTES];

    // waveform state
    logic [1:0] planePhase;
    logic polarity;
    logic baseTick;
    logic blinkOff;

    // apb decode
    wire apbAccess = psel && penable;
    wire apbDone = apbAccess && pready;
    wire [11:0] segOffset = paddr - `LCDSW_OFS_SEGMEM;
    wire [IDXW-1:0] segIndex = segOffset[IDXW+1:2];
    wire hitCtrl = (paddr == `LCDSW_OFS_CTRL);
    wire hitFlash = (paddr == `LCDSW_OFS_FLASH);
    wire hitSupply = (paddr == `LCDSW_OFS_SUPPLY);
    wire hitStatus = (paddr == `LCDSW_OFS_STATUS);
    wire hitSeg = (paddr >= `LCDSW_OFS_SEGMEM) && (segOffset[1:0] == 2'h0)
        && (segOffset[11:2] < 10'(BYTES));
    wire hitAny = hitCtrl || hitFlash || hitSupply || hitStatus || hitSeg;
    // status is read only; a write there is refused
    wire badAccess = !hitAny || (pwrite && hitStatus);
    wire regWrite = apbDone && pwrite && !badAccess;

    wire [31:0] ctrlValue = {25'h000_0000, memoryBankSelect, displayEnable,
        baseFrequencySelect, dutySelect};
    wire [31:0] flashValue = {24'h00_0000, blinkEnable, 3'h0, blinkAllSelect,
        flashRateExponent};
    wire [31:0] supplyValue = {30'h0000_0000, powerSourceSelect};
    wire [31:0] statusValue = {24'h00_0000, supplySwitch, blinkOff, polarity,
        1'b0, planePhase};
    wire [31:0] segValue = {24'h00_0000, segmentMemory[memoryBankSelect][segIndex]};

    wire [31:0] readMux;
    assign readMux = hitCtrl ? ctrlValue
        : hitFlash ? flashValue
        : hitSupply ? supplyValue
        : hitStatus ? statusValue
        : hitSeg ? segValue
        : 32'h0000_0000;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbAccess && !pready;
            pslverr <= apbAccess && !pready && badAccess;
            prdata <= (apbAccess && !pready && !pwrite) ? readMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {memoryBankSelect, displayEnable, baseFrequencySelect, dutySelect} <=
                7'(`LCDSW_CTRL_RESET);
        end else if (regWrite && hitCtrl) begin
            dutySelect <= pwdata[`LCDSW_CTRL_DUTY_LSB +: 2];
            baseFrequencySelect <= pwdata[`LCDSW_CTRL_BASE_LSB +: 3];
            displayEnable <= pwdata[`LCDSW_CTRL_ENABLE_BIT];
            memoryBankSelect <= pwdata[`LCDSW_CTRL_BANK_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {blinkEnable, blinkAllSelect, flashRateExponent} <= 5'(`LCDSW_FLASH_RESET);
        end else if (regWrite && hitFlash) begin
            flashRateExponent <= pwdata[`LCDSW_FLASH_RATE_LSB +: 3];
            blinkAllSelect <= pwdata[`LCDSW_FLASH_ALL_BIT];
            blinkEnable <= pwdata[`LCDSW_FLASH_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            powerSourceSelect <= 2'(`LCDSW_SUPPLY_RESET);
        end else if (regWrite && hitSupply) begin
            powerSourceSelect <= pwdata[`LCDSW_SUPPLY_SRC_LSB +: 2];
        end
    end

    // segment memory: low nibble even frontplane, high nibble odd one
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < BYTES; i++) begin
                    segmentMemory[b][i] <= 8'h00;
                end
            end
        end else if (regWrite && hitSeg) begin
            segmentMemory[memoryBankSelect][segIndex] <= pwdata[7:0];
        end
    end

    // supply switch decode: vdd, internal reference, external pin
    wire [2:0] next_supplySwitch;
    assign next_supplySwitch =
        (powerSourceSelect == lcdsw_pkg::LCDSW_SUP_VDD) ? 3'h1
        : (powerSourceSelect == lcdsw_pkg::LCDSW_SUP_INTREF) ? 3'h2
        : (powerSourceSelect == lcdsw_pkg::LCDSW_SUP_EXTPIN) ? 3'h4
        : 3'h0;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            supplySwitch <= 3'h0;
        end else begin
            supplySwitch <= next_supplySwitch;
        end
    end

    lcdsw_rate_gen #(
        .BASE_DIV(BASE_DIV)
    ) u_rate (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .baseFrequencySelect(baseFrequencySelect),
        .flashRateExponent(flashRateExponent),
        .blinkRun(blinkEnable && displayEnable),
        .baseTick(baseTick),
        .blinkOff(blinkOff)
    );

    // one backplane phase per base tick; polarity flips each frame
    wire lastPhase = (planePhase >= dutySelect);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            planePhase <= 2'h0;
            polarity <= 1'b0;
        end else if (!displayEnable) begin
            planePhase <= 2'h0;
            polarity <= 1'b0;
        end else if (baseTick) begin
            planePhase <= lastPhase ? 2'h0 : planePhase + 2'h1;
            polarity <= lastPhase ? ~polarity : polarity;
        end
    end

    // shared pin is a backplane only at quarter duty
    wire sharedIsBackplane = (dutySelect == lcdsw_pkg::LCDSW_DUTY_4);
    wire blinkAllActive = blinkEnable && blinkAllSelect && memoryBankSelect;
    wire blinkSomeActive = blinkEnable && !blinkAllSelect;

    // frontplane 40 is the shared pin when it serves as a frontplane
    wire [FP_COUNT:0] next_fpLevel;
    genvar n;
    generate
        for (n = 0; n <= FP_COUNT; n++) begin : g_fp
            wire [3:0] shownBits = segmentMemory[memoryBankSelect][n/2][(n%2)*4 +: 4];
            wire [3:0] bothBits = segmentMemory[0][n/2][(n%2)*4 +: 4]
                & segmentMemory[1][n/2][(n%2)*4 +: 4];
            wire segOn = shownBits[planePhase];
            wire blinks = blinkAllActive || (blinkSomeActive && bothBits[planePhase]);
            wire litNow = segOn && !(blinks && blinkOff);
            // lit segments differ from the active backplane level
            assign next_fpLevel[n] = litNow ? polarity : ~polarity;
        end
    endgenerate

    wire [3:0] next_bpLevel;
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_bp
            assign next_bpLevel[k] = (planePhase == 2'(k)) ? ~polarity : polarity;
        end
    endgenerate

    // unused backplanes at lower duty idle at the inactive level
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            backplaneOutput <= 3'h0;
            frontplaneOutput <= '0;
            sharedPlaneOutput <= 1'b0;
        end else begin
            backplaneOutput <= next_bpLevel[2:0];
            frontplaneOutput <= next_fpLevel[FP_COUNT-1:0];
            sharedPlaneOutput <= sharedIsBackplane ? next_bpLevel[3]
                : next_fpLevel[FP_COUNT];
        end
    end

    // released until software enables the display
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            backplaneOutputOe_b <= 3'h7;
            frontplaneOutputOe_b <= '1;
            sharedPlaneOutputOe_b <= 1'b1;
        end else begin
            backplaneOutputOe_b <= {3{!displayEnable}};
            frontplaneOutputOe_b <= {FP_COUNT{!displayEnable}};
            sharedPlaneOutputOe_b <= !displayEnable;
        end
    end
endmodule : lcdsw_top

// ===== tb/lcdsw_top_properties.sv
// Purpose: port checks of the segment lcd driver
// Assumes: one clock, rst_b async active low
// Notes: bound to lcdsw_top below
`timescale 1ns/100ps
`include "lcdsw_regs.svh"
module lcdsw_top_props #(
    parameter int FP_COUNT = 40
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] backplaneOutput,
    input wire logic [2:0] backplaneOutputOe_b,
    input wire logic [FP_COUNT-1:0] frontplaneOutput,
    input wire logic [FP_COUNT-1:0] frontplaneOutputOe_b,
    input wire logic sharedPlaneOutput,
    input wire logic sharedPlaneOutputOe_b,
    input wire logic [2:0] supplySwitch
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic apbDone, supWr, released;
    assign apbDone = psel && penable && pready;
    assign supWr = apbDone && pwrite && paddr == `LCDSW_OFS_SUPPLY;
    assign released = &{backplaneOutputOe_b, frontplaneOutputOe_b, sharedPlaneOutputOe_b};
    reset_release_a: assert property ($rose(rst_b) |-> released)
        else $error("plane pin driven at reset release");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    ready_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    refused_err_a: assert property (apbDone && (paddr == 12'h010
        || (pwrite && paddr == `LCDSW_OFS_STATUS)) |-> pslverr) else $error("no error reply");
    // code lands at the write edge, switch pins follow one edge later
    supply_decode_a: assert property (supWr |-> ##2
        supplySwitch == (($past(pwdata[1:0], 2) == 2'h3) ? 3'h0
        : 3'h1 << $past(pwdata[1:0], 2)))
        else $error("supply switches wrong");
    ext_supply_a: assert property (supWr && pwdata[1:0] == 2'h2 |-> ##2 supplySwitch == 3'h4)
        else $error("external supply not chosen");
    enable_drive_a: assert property (apbDone && pwrite && paddr == `LCDSW_OFS_CTRL
        && pwdata[`LCDSW_CTRL_ENABLE_BIT] |-> ##2 !sharedPlaneOutputOe_b
        && !(|frontplaneOutputOe_b))
        else $error("planes not driven after enable");
    shared_drive_a: assert property (sharedPlaneOutputOe_b == frontplaneOutputOe_b[0])
        else $error("shared pin drive differs");
    cover property (apbDone && pslverr);
    cover property (supWr && pwdata[1:0] == 2'h2);
    cover property ($fell(sharedPlaneOutputOe_b));
endmodule : lcdsw_top_props
bind lcdsw_top lcdsw_top_props #(.FP_COUNT(FP_COUNT)) lcdsw_top_props_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .backplaneOutput(backplaneOutput), .backplaneOutputOe_b(backplaneOutputOe_b),
    .frontplaneOutput(frontplaneOutput), .frontplaneOutputOe_b(frontplaneOutputOe_b),
    .sharedPlaneOutput(sharedPlaneOutput), .sharedPlaneOutputOe_b(sharedPlaneOutputOe_b),
    .supplySwitch(supplySwitch));

// ===== tb/lcdsw_glass_model.sv
// Purpose: glass model, names the active backplane and the lit segments
// Assumes: one backplane differs from the rest in each phase
// Notes: any released pin makes the row invalid
`timescale 1ns/100ps
module lcdsw_glass_model (
    input wire logic [2:0] backplaneOutput,
    input wire logic [2:0] backplaneOutputOe_b,
    input wire logic [39:0] frontplaneOutput,
    input wire logic [39:0] frontplaneOutputOe_b,
    input wire logic sharedPlaneOutput,
    input wire logic sharedPlaneOutputOe_b,
    input wire logic fourPlanes,
    output logic rowValid,
    output logic [1:0] activePlane,
    output logic [40:0] litRow
);
    logic [3:0] planes;
    logic pol;
    assign planes = {sharedPlaneOutput, backplaneOutput};
    // idle planes all sit at the polarity level, the odd one out is active
    assign pol = (planes[0] == planes[1]) ? planes[0] : planes[2];
    assign rowValid = ~|{backplaneOutputOe_b, frontplaneOutputOe_b, sharedPlaneOutputOe_b};
    assign activePlane = (planes[0] != pol) ? 2'h0 : (planes[1] != pol) ? 2'h1 :
        (planes[2] != pol) ? 2'h2 : 2'h3;
    assign litRow = {!fourPlanes && sharedPlaneOutput == pol, frontplaneOutput ~^ {40{pol}}};
endmodule : lcdsw_glass_model

// ===== tb/lcd_segment_waveform_blink_tb.sv
// Purpose: bench for lcdsw_top over apb with a glass model
// Assumes: base divider cut to 4 cycles
// Notes: phase and blink spans are measured at the glass model
`timescale 1ns/100ps
`include "lcdsw_regs.svh"
module lcd_segment_waveform_blink_tb;
    localparam int DIV = 4;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic four = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, v;
    logic pready, pslverr, e, sp, spOe, ok, dark;
    logic [2:0] bp, bpOe, sw;
    logic [39:0] fp, fpOe;
    logic [1:0] act;
    logic [40:0] row;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    assign dark = ok && row == 41'h0;
    lcdsw_top #(.BASE_DIV(DIV)) lcdsw_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .backplaneOutput(bp), .backplaneOutputOe_b(bpOe),
        .frontplaneOutput(fp), .frontplaneOutputOe_b(fpOe), .sharedPlaneOutput(sp),
        .sharedPlaneOutputOe_b(spOe), .supplySwitch(sw));
    lcdsw_glass_model lcdsw_glass_model_inst (.backplaneOutput(bp), .backplaneOutputOe_b(bpOe),
        .frontplaneOutput(fp), .frontplaneOutputOe_b(fpOe), .sharedPlaneOutput(sp),
        .sharedPlaneOutputOe_b(spOe), .fourPlanes(four), .rowValid(ok), .activePlane(act),
        .litRow(row));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no wait bound here: only the watchdog ends a hung transfer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // length of a span of the active plane or of the dark row; first spans skipped
    task automatic span(input logic w, input int reps, output int len);
        logic [1:0] s;
        for (int k = 0; k < reps; k++) begin
            s = w ? {1'b0, dark} : act;
            len = 0;
            while ((w ? {1'b0, dark} : act) === s && len < 20000) begin
                @(posedge sys_clk);
                len++;
            end
        end
    endtask : span
    task automatic fill(input logic [7:0] d);
        for (int i = 0; i < 21; i++) begin
            apb(1'b1, 12'(`LCDSW_OFS_SEGMEM + 4 * i), {24'h00_0000, d});
        end
        for (int i = 0; i < 21; i++) begin
            apb(1'b0, 12'(`LCDSW_OFS_SEGMEM + 4 * i), 32'h0000_0000);
            check("segment byte", v, {24'h00_0000, d});
        end
    endtask : fill
    task automatic phases(input int sel, input logic f);
        logic [3:0] seen;
        int len;
        four = f;
        seen = 4'h0;
        apb(1'b1, `LCDSW_OFS_CTRL, 32'h0000_0022 | 32'(f) | 32'(sel << 2));
        span(1'b0, 3, len);
        repeat (8) begin
            span(1'b0, 1, len);
            check("phase span", len, DIV << sel);
            seen[act] = 1'b1;
            check("lit row", row, act == 2'h0 ? {!f, 40'h55_5555_5555} :
                act == 2'h1 ? 41'hAA_AAAA_AAAA : 41'h0);
        end
        check("planes used", seen, f ? 4'hF : 4'h7);
        check("shared drive", spOe, 1'b0);
    endtask : phases
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("released", {bpOe, fpOe, spOe}, {44{1'b1}});
        check("supply reset", sw, 3'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0000_0000);
            check("reset value", v, 32'h0000_0000);
        end
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `LCDSW_OFS_SUPPLY, 32'(c));
            apb(1'b0, `LCDSW_OFS_STATUS, 32'h0000_0000);
            check("switch", sw, c == 3 ? 3'h0 : 3'h1 << c);
            check("status switch", v[7:5], c == 3 ? 3'h0 : 3'h1 << c);
        end
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("unmapped", {e, v}, 33'h1_0000_0000);
        apb(1'b1, `LCDSW_OFS_STATUS, 32'h0000_00FF);
        check("status write", e, 1'b1);
        $display("test supply and bus done");
        apb(1'b1, `LCDSW_OFS_CTRL, 32'h0000_0000);
        fill(8'h21);
        apb(1'b1, `LCDSW_OFS_CTRL, 32'h0000_0040);
        fill(8'hFF);
        phases(0, 1'b1);
        phases(7, 1'b0);
        $display("test memory and waveform done");
        apb(1'b1, `LCDSW_OFS_CTRL, 32'h0000_0062);
        for (int r = 0; r < 8; r += 7) begin
            apb(1'b1, `LCDSW_OFS_FLASH, 32'h0000_0000);
            apb(1'b1, `LCDSW_OFS_FLASH, 32'h0000_0088 | 32'(r));
            span(1'b1, 2, n);
            check("blink span", n, DIV << (4 + r));
            span(1'b1, 1, n);
            check("blink span", n, DIV << (4 + r));
        end
        apb(1'b1, `LCDSW_OFS_FLASH, 32'h0000_0000);
        apb(1'b1, `LCDSW_OFS_FLASH, 32'h0000_0080);
        n = 0;
        while (!(act == 2'h0 && row != {41{1'b1}}) && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        check("both banks", row, 41'hAA_AAAA_AAAA);
        $display("test blink done");
        close_out();
    end
    initial begin
        #1000000;
        bad_count++;
        close_out();
    end
endmodule : lcd_segment_waveform_blink_tb
